/* File: rtl/irq_clk_ctrl.sv */
`timescale 1ns/1ns
module irq_clk_ctrl #(
  parameter bit                    TWO_TIMERS = 1'b1, // Timer1 present
  parameter int unsigned           STACK_PTR_W = 4    // Stack pointer width
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // Avalon-MM slave
  input  wire logic [5:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  input  wire logic [3:0]          byteenable,
  output logic [31:0]              readdata,
  output logic                     waitrequest,
  // Core sequencer side
  input  wire logic                phase2_pulse,
  input  wire logic                return_from_interrupt,
  input  wire logic                subroutine_return,
  input  wire logic                stack_full,
  input  wire logic [STACK_PTR_W-1:0] stack_pointer,
  input  wire logic                halt_cmd,
  output logic                     irq_call,
  output logic [11:0]              irq_vector,
  output logic                     push_pc,
  output logic                     pop_pc,
  output logic                     wake,
  // Event sources
  input  wire logic                ext_irq_b,
  input  wire logic                timer0_ovf,
  input  wire logic                timer1_ovf,
  // Configuration options
  input  wire irq_clk_pkg::osc_mode_t osc_mode,
  input  wire irq_clk_pkg::irc_freq_t irc_freq,
  input  wire logic                wdt_osc_disable,
  // Clock gating outputs
  output logic                     sys_osc_run,
  output logic                     rc_osc_run,
  output logic                     rtc_osc_run,
  output logic                     wdt_osc_run,
  output logic                     sys_clk_is_rtc,
  output logic                     osc_pins_are_io,
  output irq_clk_pkg::irc_freq_t   irc_freq_sel,
  output irq_clk_pkg::op_mode_t    op_mode
);

  // Interrupt control bits and flags
  logic                            gie_reg, gie_next;
  logic                            een_reg, een_next;
  logic                            t0en_reg, t0en_next;
  logic                            t1en_reg, t1en_next;
  logic                            eflag_reg, eflag_next;
  logic                            t0flag_reg, t0flag_next;
  logic                            t1flag_reg, t1flag_next;
  // Clock select and power-down state
  logic                            clksel_reg, clksel_next;
  logic                            halt_reg, halt_next;
  // Pin history for edge detect; pin taken as synchronous
  logic                            pin_reg;
  // Bus answer registers
  logic [31:0]                     rdata_reg, rdata_next;
  logic                            ack_reg, ack_next;
  // Core strobes
  logic                            call_reg, call_next;
  logic [11:0]                     vec_reg, vec_next;
  logic                            pop_reg, pop_next;
  logic                            wake_reg, wake_next;
  // Clock outputs
  logic                            sysosc_reg, rcosc_reg, rtcosc_reg;
  logic                            wdtosc_reg, isrtc_reg, pinio_reg;
  irq_clk_pkg::irc_freq_t          freq_reg;
  irq_clk_pkg::op_mode_t           opm_reg, opm_next;

  // Decoded helpers
  logic                            ext_edge;
  logic                            t1_evt;
  logic                            wr_ctl, wr_clk;
  logic [7:0]                      ctl_view;
  logic                            ext_go, t0_go, t1_go;
  logic                            rtc_mode;

  // Falling edge on the active-low pin; sets no flag in power-down, but still wakes
  assign ext_edge = pin_reg & ~ext_irq_b;
  assign t1_evt   = TWO_TIMERS & timer1_ovf;
  // Writes take effect on the first request cycle, while waitrequest is still high
  assign wr_ctl   = write & ~ack_reg & (address == irq_clk_pkg::ADDR_IRQ_CTL)
                    & byteenable[0];
  assign wr_clk   = write & ~ack_reg & (address == irq_clk_pkg::ADDR_CLKCTL)
                    & byteenable[0];
  assign rtc_mode = (osc_mode == irq_clk_pkg::OSC_INT_RC_RTC);

  // Readable control view; absent timer1 bits read zero
  always_comb begin
    ctl_view = irq_clk_pkg::IRQ_CTL_RESET;
    ctl_view[irq_clk_pkg::BIT_GIE]    = gie_reg;
    ctl_view[irq_clk_pkg::BIT_EEN]    = een_reg;
    ctl_view[irq_clk_pkg::BIT_T0EN]   = t0en_reg;
    ctl_view[irq_clk_pkg::BIT_T1EN]   = t1en_reg & TWO_TIMERS;
    ctl_view[irq_clk_pkg::BIT_EFLAG]  = eflag_reg;
    ctl_view[irq_clk_pkg::BIT_T0FLAG] = t0flag_reg;
    ctl_view[irq_clk_pkg::BIT_T1FLAG] = t1flag_reg & TWO_TIMERS;
  end

  // Acceptance by fixed priority, gated by global enable and stack
  always_comb begin
    ext_go = gie_reg & ~stack_full & een_reg & eflag_reg;
    t0_go  = gie_reg & ~stack_full & t0en_reg & t0flag_reg & ~ext_go;
    t1_go  = gie_reg & ~stack_full & t1en_reg & t1flag_reg & TWO_TIMERS
             & ~ext_go & ~t0_go;
  end

  // Interrupt state next values
  always_comb begin
    gie_next    = gie_reg;
    een_next    = een_reg;
    t0en_next   = t0en_reg;
    t1en_next   = t1en_reg;
    eflag_next  = eflag_reg;
    t0flag_next = t0flag_reg;
    t1flag_next = t1flag_reg;
    call_next   = 1'b0;
    vec_next    = vec_reg;
    pop_next    = 1'b0;
    // Software writes: enables, and direct flag set or clear
    if (wr_ctl) begin
      gie_next    = writedata[irq_clk_pkg::BIT_GIE];
      een_next    = writedata[irq_clk_pkg::BIT_EEN];
      t0en_next   = writedata[irq_clk_pkg::BIT_T0EN];
      t1en_next   = writedata[irq_clk_pkg::BIT_T1EN] & TWO_TIMERS;
      eflag_next  = writedata[irq_clk_pkg::BIT_EFLAG];
      t0flag_next = writedata[irq_clk_pkg::BIT_T0FLAG];
      t1flag_next = writedata[irq_clk_pkg::BIT_T1FLAG] & TWO_TIMERS;
    end
    // Service happens only on a phase2 pulse
    if (phase2_pulse && !halt_reg) begin
      if (ext_go) begin
        eflag_next = 1'b0;
        gie_next   = 1'b0;
        call_next  = 1'b1;
        vec_next   = irq_clk_pkg::VEC_EXT;
      end else if (t0_go) begin
        t0flag_next = 1'b0;
        gie_next    = 1'b0;
        call_next   = 1'b1;
        vec_next    = irq_clk_pkg::VEC_T0;
      end else if (t1_go) begin
        t1flag_next = 1'b0;
        gie_next    = 1'b0;
        call_next   = 1'b1;
        vec_next    = irq_clk_pkg::VEC_T1;
      end else if (return_from_interrupt) begin
        gie_next = 1'b1;
        pop_next = 1'b1;
      end else if (subroutine_return) begin
        pop_next = 1'b1;
      end
    end
    // Hardware events win over clears, even when disabled
    if (ext_edge && !halt_reg) eflag_next = 1'b1;
    if (timer0_ovf) t0flag_next = 1'b1;
    if (t1_evt) t1flag_next = 1'b1;
  end

  // Power-down, clock select and wake next values
  always_comb begin
    clksel_next = clksel_reg;
    halt_next   = halt_reg;
    wake_next   = 1'b0;
    opm_next    = irq_clk_pkg::OPM_NORMAL;
    if (wr_clk) clksel_next = writedata[irq_clk_pkg::BIT_CLKSEL];
    // Any source, even disabled, ends power-down; pin edge read raw
    if (halt_reg && ((pin_reg & ~ext_irq_b) | timer0_ovf | t1_evt)) begin
      halt_next = 1'b0;
      wake_next = 1'b1;
    end else if (halt_cmd) begin
      halt_next = 1'b1;
    end
    if (halt_next) opm_next = irq_clk_pkg::OPM_IDLE;
    else if (rtc_mode && clksel_next) opm_next = irq_clk_pkg::OPM_SLOW;
  end

  // Bus answer: one wait cycle, then acknowledge
  always_comb begin
    ack_next  = (read | write) & ~ack_reg;
    rdata_next = rdata_reg;
    if (read && !ack_reg) begin
      case (address)
        irq_clk_pkg::ADDR_IRQ_CTL: rdata_next = {24'h00_0000, ctl_view};
        irq_clk_pkg::ADDR_CLKCTL: rdata_next = {31'h0000_0000, clksel_reg};
        irq_clk_pkg::ADDR_STATUS: rdata_next = {24'h00_0000, 1'b0,
                                    opm_reg == irq_clk_pkg::OPM_SLOW,
                                    halt_reg, stack_full,
                                    stack_pointer[3:0]};
        default:                  rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Register update
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gie_reg    <= 1'b0;
      een_reg    <= 1'b0;
      t0en_reg   <= 1'b0;
      t1en_reg   <= 1'b0;
      eflag_reg  <= 1'b0;
      t0flag_reg <= 1'b0;
      t1flag_reg <= 1'b0;
      clksel_reg <= 1'b0;
      halt_reg   <= 1'b0;
      pin_reg    <= 1'b1;
      rdata_reg  <= 32'h0000_0000;
      ack_reg    <= 1'b0;
      call_reg   <= 1'b0;
      vec_reg    <= 12'h000;
      pop_reg    <= 1'b0;
      wake_reg   <= 1'b0;
      opm_reg    <= irq_clk_pkg::OPM_NORMAL;
    end else begin
      gie_reg    <= gie_next;
      een_reg    <= een_next;
      t0en_reg   <= t0en_next;
      t1en_reg   <= t1en_next;
      eflag_reg  <= eflag_next;
      t0flag_reg <= t0flag_next;
      t1flag_reg <= t1flag_next;
      clksel_reg <= clksel_next;
      halt_reg   <= halt_next;
      pin_reg    <= ext_irq_b;
      rdata_reg  <= rdata_next;
      ack_reg    <= ack_next;
      call_reg   <= call_next;
      vec_reg    <= vec_next;
      pop_reg    <= pop_next;
      wake_reg   <= wake_next;
      opm_reg    <= opm_next;
    end
  end

  // Oscillator gating, registered so outputs come from flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sysosc_reg <= 1'b1;
      rcosc_reg  <= 1'b1;
      rtcosc_reg <= 1'b0;
      wdtosc_reg <= 1'b1;
      isrtc_reg  <= 1'b0;
      pinio_reg  <= 1'b0;
      freq_reg   <= irq_clk_pkg::IRC_12MHZ;
    end else begin
      sysosc_reg <= ~halt_next;
      rcosc_reg  <= (osc_mode == irq_clk_pkg::OSC_INT_RC_IO ||
                     osc_mode == irq_clk_pkg::OSC_INT_RC_RTC)
                    & ~halt_next & ~(rtc_mode & clksel_next);
      rtcosc_reg <= rtc_mode;
      wdtosc_reg <= ~wdt_osc_disable;
      isrtc_reg  <= rtc_mode & clksel_next;
      pinio_reg  <= (osc_mode == irq_clk_pkg::OSC_INT_RC_IO);
      freq_reg   <= irc_freq;
    end
  end

  assign readdata        = rdata_reg;
  assign waitrequest     = ~ack_reg;
  assign irq_call        = call_reg;
  assign push_pc         = call_reg;
  assign irq_vector      = vec_reg;
  assign pop_pc          = pop_reg;
  assign wake            = wake_reg;
  assign sys_osc_run     = sysosc_reg;
  assign rc_osc_run      = rcosc_reg;
  assign rtc_osc_run     = rtcosc_reg;
  assign wdt_osc_run     = wdtosc_reg;
  assign sys_clk_is_rtc  = isrtc_reg;
  assign osc_pins_are_io = pinio_reg;
  assign irc_freq_sel    = freq_reg;
  assign op_mode         = opm_reg;

  // Assertions
  property p_call_clears_gie;
    @(posedge clk) disable iff (!rst_b)
      $rose(call_reg) |-> !gie_reg;
  endproperty
  a_call_clears_gie: assert property (p_call_clears_gie)
    else $error("global enable still set after call");

  property p_no_call_stack_full;
    @(posedge clk) disable iff (!rst_b)
      stack_full |=> !call_reg;
  endproperty
  a_no_call_stack_full: assert property (p_no_call_stack_full)
    else $error("call taken with stack full");

  property p_ext_edge_sets;
    @(posedge clk) disable iff (!rst_b)
      (ext_edge && !halt_reg) |=> eflag_reg || (call_reg &&
        vec_reg == irq_clk_pkg::VEC_EXT);
  endproperty
  a_ext_edge_sets: assert property (p_ext_edge_sets)
    else $error("pin edge did not set flag");

  property p_ext_vector;
    @(posedge clk) disable iff (!rst_b)
      (phase2_pulse && !halt_reg && ext_go) |=>
        call_reg && vec_reg == irq_clk_pkg::VEC_EXT;
  endproperty
  a_ext_vector: assert property (p_ext_vector)
    else $error("external call wrong");

  property p_t0_vector;
    @(posedge clk) disable iff (!rst_b)
      (phase2_pulse && !halt_reg && !ext_go && t0_go) |=>
        call_reg && vec_reg == irq_clk_pkg::VEC_T0;
  endproperty
  a_t0_vector: assert property (p_t0_vector)
    else $error("timer0 call wrong");

  property p_t1_vector;
    @(posedge clk) disable iff (!rst_b)
      (phase2_pulse && !halt_reg && t1_go) |=>
        call_reg && vec_reg == irq_clk_pkg::VEC_T1;
  endproperty
  a_t1_vector: assert property (p_t1_vector)
    else $error("timer1 call wrong");

  property p_return_from_interrupt_sets_gie;
    @(posedge clk) disable iff (!rst_b)
      (phase2_pulse && !halt_reg && return_from_interrupt && !ext_go
        && !t0_go && !t1_go) |=> gie_reg && pop_reg;
  endproperty
  a_return_from_interrupt_sets_gie: assert property (p_return_from_interrupt_sets_gie)
    else $error("return did not set enable");

  property p_call_needs_phase2;
    @(posedge clk) disable iff (!rst_b)
      call_reg |-> $past(phase2_pulse);
  endproperty
  a_call_needs_phase2: assert property (p_call_needs_phase2)
    else $error("call off phase2");

  property p_masked;
    @(posedge clk) disable iff (!rst_b)
      !gie_reg |=> !call_reg;
  endproperty
  a_masked: assert property (p_masked)
    else $error("call while masked");

  property p_wake;
    @(posedge clk) disable iff (!rst_b)
      (halt_reg && timer0_ovf) |=> wake_reg ##1 !wake_reg;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on timer");

  c_ext_call: cover property (@(posedge clk) disable iff (!rst_b)
    call_reg && vec_reg == irq_clk_pkg::VEC_EXT);
  c_t1_call: cover property (@(posedge clk) disable iff (!rst_b)
    call_reg && vec_reg == irq_clk_pkg::VEC_T1);
  c_wake: cover property (@(posedge clk) disable iff (!rst_b) wake_reg);
  c_slow: cover property (@(posedge clk) disable iff (!rst_b)
    opm_reg == irq_clk_pkg::OPM_SLOW);
endmodule

/* File: rtl/irq_clk_pkg.sv */
package irq_clk_pkg;
  // Register byte offsets (printed offset is not a multiple of four)
  localparam int unsigned          IRQ_CTL_INDEX   = 32'h0000_000b;
  localparam logic [5:0]           ADDR_IRQ_CTL    = 6'h2c;
  localparam logic [5:0]           ADDR_CLKCTL     = 6'h30;
  localparam logic [5:0]           ADDR_STATUS     = 6'h34;
  // Interrupt control field positions
  localparam int unsigned          BIT_GIE         = 0;
  localparam int unsigned          BIT_EEN         = 1;
  localparam int unsigned          BIT_T0EN        = 2;
  localparam int unsigned          BIT_T1EN        = 3;
  localparam int unsigned          BIT_EFLAG       = 4;
  localparam int unsigned          BIT_T0FLAG      = 5;
  localparam int unsigned          BIT_T1FLAG      = 6;
  // Clock control field positions
  localparam int unsigned          BIT_CLKSEL      = 0;
  // Reset values
  localparam logic [7:0]           IRQ_CTL_RESET   = 8'h00;
  // Vectors
  localparam logic [11:0]          VEC_EXT         = 12'h004;
  localparam logic [11:0]          VEC_T0          = 12'h008;
  localparam logic [11:0]          VEC_T1          = 12'h00c;
  // Oscillator option encodings
  typedef enum logic [1:0] {
    OSC_EXT_RC, OSC_EXT_XTAL, OSC_INT_RC_IO, OSC_INT_RC_RTC
  } osc_mode_t;
  typedef enum logic [1:0] {
    IRC_12MHZ, IRC_8MHZ, IRC_4MHZ, IRC_RSVD
  } irc_freq_t;
  // Operating modes in RC with RTC option
  typedef enum logic [1:0] {
    OPM_NORMAL, OPM_SLOW, OPM_IDLE
  } op_mode_t;
  // Empty stack pointer value
  localparam logic [3:0]           STACK_EMPTY     = 4'h0;
endpackage

/* File: verification/cpu_seq_model.sv */
`timescale 1ns/1ns
// Core sequencer stand-in: phase2 timing, return commands and return stack
module cpu_seq_model #(
  parameter int unsigned DEPTH = 4  // Return stack levels
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // From the controller
  input  wire logic       push_pc,
  input  wire logic       pop_pc,
  // From the bench
  input  wire logic       call_req,
  input  wire logic       ret_req,
  input  wire logic       return_from_interrupt_req,
  // To the controller
  output logic            phase2_pulse,
  output logic            return_from_interrupt,
  output logic            subroutine_return,
  output logic            stack_full,
  output logic [3:0]      stack_pointer
);
  logic [1:0] ph_reg;     // Four clocks per instruction cycle
  logic       ret_reg;    // Plain return waiting for phase2
  logic       return_from_interrupt_reg;   // Interrupt return waiting for phase2
  logic [3:0] depth_reg;  // Stack depth in use

  // Returns only issue on a phase2 pulse, like a real decoder
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_reg   <= 2'h0;
      ret_reg  <= 1'b0;
      return_from_interrupt_reg <= 1'b0;
      depth_reg <= 4'h0;
    end else begin
      ph_reg   <= ph_reg + 2'h1;
      ret_reg  <= ret_req | (ret_reg & ~phase2_pulse);
      return_from_interrupt_reg <= return_from_interrupt_req | (return_from_interrupt_reg & ~phase2_pulse);
      // Software calls and interrupt pushes share one stack
      depth_reg <= depth_reg + {3'h0, push_pc | call_req} - {3'h0, pop_pc};
    end
  end

  assign phase2_pulse          = (ph_reg == 2'h3);
  assign subroutine_return     = phase2_pulse & ret_reg;
  assign return_from_interrupt = phase2_pulse & return_from_interrupt_reg;
  assign stack_full            = (depth_reg == 4'(DEPTH));
  assign stack_pointer         = depth_reg;
endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ns
module tb;
  // Bus side
  logic        clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0;
  logic [5:0]  address = 6'h00;
  logic [31:0] writedata = 32'h0000_0000, readdata;
  logic        waitrequest;
  // Sequencer side
  logic        phase2_pulse, return_from_interrupt, subroutine_return;
  logic        stack_full, irq_call, push_pc, pop_pc, wake;
  logic [3:0]  stack_pointer;
  logic [11:0] irq_vector, last_vec = 12'h000;
  logic        call_req = 1'b0, ret_req = 1'b0, return_from_interrupt_req = 1'b0;
  logic        halt_cmd = 1'b0, wdt_osc_disable = 1'b0;
  // Sources and clock outputs
  logic        ext_irq_b = 1'b1, timer0_ovf = 1'b0, timer1_ovf = 1'b0;
  logic        sys_osc_run, rc_osc_run, rtc_osc_run, wdt_osc_run;
  logic        sys_clk_is_rtc, osc_pins_are_io;
  irq_clk_pkg::osc_mode_t osc_mode = irq_clk_pkg::OSC_INT_RC_RTC;
  irq_clk_pkg::irc_freq_t irc_freq = irq_clk_pkg::IRC_12MHZ, irc_freq_sel;
  irq_clk_pkg::op_mode_t  op_mode;
  int          n_errors = 0, n_compared = 0, calls = 0, pops = 0, wakes = 0;
  int          pushes = 0;

  always #50 clk = ~clk;

  irq_clk_ctrl #(.TWO_TIMERS(1'b1), .STACK_PTR_W(4)) u_irq_clk_ctrl (
    .clk(clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hf),
    .readdata(readdata), .waitrequest(waitrequest),
    .phase2_pulse(phase2_pulse), .subroutine_return(subroutine_return),
    .return_from_interrupt(return_from_interrupt),
    .stack_full(stack_full), .stack_pointer(stack_pointer),
    .halt_cmd(halt_cmd), .irq_call(irq_call), .irq_vector(irq_vector),
    .push_pc(push_pc), .pop_pc(pop_pc), .wake(wake),
    .ext_irq_b(ext_irq_b), .timer0_ovf(timer0_ovf),
    .timer1_ovf(timer1_ovf), .osc_mode(osc_mode), .irc_freq(irc_freq),
    .wdt_osc_disable(wdt_osc_disable), .sys_osc_run(sys_osc_run),
    .rc_osc_run(rc_osc_run), .rtc_osc_run(rtc_osc_run),
    .wdt_osc_run(wdt_osc_run), .sys_clk_is_rtc(sys_clk_is_rtc),
    .osc_pins_are_io(osc_pins_are_io), .irc_freq_sel(irc_freq_sel),
    .op_mode(op_mode));

  cpu_seq_model #(.DEPTH(4)) u_cpu_seq_model (
    .clk(clk), .rst_b(rst_b), .push_pc(push_pc), .pop_pc(pop_pc),
    .call_req(call_req), .ret_req(ret_req), .return_from_interrupt_req(return_from_interrupt_req),
    .phase2_pulse(phase2_pulse), .subroutine_return(subroutine_return),
    .return_from_interrupt(return_from_interrupt),
    .stack_full(stack_full), .stack_pointer(stack_pointer));

  // Event counters, sampled on the edge that ends each pulse
  always @(posedge clk) begin
    if (irq_call) begin
      calls++;
      last_vec = irq_vector;
    end
    if (pop_pc) pops++;
    if (push_pc) pushes++;
    if (wake) wakes++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
  endtask

  // Request held until waitrequest is seen low; only the watchdog cuts it
  task automatic bus_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    address   <= a;
    writedata <= {24'h00_0000, d};
    write     <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write     <= 1'b0;
  endtask

  task automatic bus_rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    address <= a;
    read    <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    chk(readdata, {24'h00_0000, e});
    read    <= 1'b0;
  endtask

  // Mask: bit0 pin falling edge, bit1 timer0, bit2 timer1
  task automatic src(input logic [2:0] m);
    @(posedge clk);
    ext_irq_b  <= ~m[0];
    timer0_ovf <= m[1];
    timer1_ovf <= m[2];
    @(posedge clk);
    ext_irq_b  <= 1'b1;
    timer0_ovf <= 1'b0;
    timer1_ovf <= 1'b0;
  endtask

  task automatic ret_cmd(input logic iret);
    @(posedge clk);
    if (iret) return_from_interrupt_req <= 1'b1;
    else ret_req <= 1'b1;
    @(posedge clk);
    return_from_interrupt_req <= 1'b0;
    ret_req  <= 1'b0;
  endtask

  // Exactly one call with the given vector within b cycles
  task automatic expect_call(input logic [11:0] v, input int b);
    int c0;
    int k;
    int q0;
    c0 = calls;
    q0 = pushes;
    for (k = 0; k < b && calls == c0; k++) @(negedge clk);
    chk(32'(calls - c0), 32'h0000_0001);
    chk(32'(pushes - q0), 32'h0000_0001);
    chk({20'h0_0000, last_vec}, {20'h0_0000, v});
  endtask

  task automatic t_regs;
    bus_rd(irq_clk_pkg::ADDR_IRQ_CTL, 8'h00);
    bus_rd(6'h3c, 8'h00);
    bus_wr(irq_clk_pkg::ADDR_IRQ_CTL, 8'hfe);
    bus_rd(irq_clk_pkg::ADDR_IRQ_CTL, 8'h7e);
    bus_wr(irq_clk_pkg::ADDR_IRQ_CTL, 8'h00);
    bus_rd(irq_clk_pkg::ADDR_IRQ_CTL, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_ext;
    int c0;
    do_reset;
    bus_wr(irq_clk_pkg::ADDR_IRQ_CTL, 8'h02);
    c0 = calls;
    src(3'b001);
    repeat (8) @(negedge clk);
    bus_rd(irq_clk_pkg::ADDR_IRQ_CTL, 8'h12);
    chk(32'(calls - c0), 32'h0000_0000);
    bus_wr(irq_clk_pkg::ADDR_IRQ_CTL, 8'h13);
    expect_call(irq_clk_pkg::VEC_EXT, 8);
    bus_rd(irq_clk_pkg::ADDR_IRQ_CTL, 8'h02);
    // Nesting from inside the handler
    bus_wr(irq_clk_pkg::ADDR_IRQ_CTL, 8'h05);
    src(3'b010);
    expect_call(irq_clk_pkg::VEC_T0, 8);
    chk({28'h000_0000, stack_pointer}, 32'h0000_0002);
    $display("test ext done");
  endtask

  task automatic t_prio;
    int p0;
    do_reset;
    p0 = pops;
    bus_wr(irq_clk_pkg::ADDR_IRQ_CTL, 8'h0e);
    src(3'b111);
    repeat (2) @(negedge clk);
    bus_rd(irq_clk_pkg::ADDR_IRQ_CTL, 8'h7e);
    bus_wr(irq_clk_pkg::ADDR_IRQ_CTL, 8'h7f);
    expect_call(irq_clk_pkg::VEC_EXT, 8);
    bus_rd(irq_clk_pkg::ADDR_IRQ_CTL, 8'h6e);
    ret_cmd(1'b1);
    expect_call(irq_clk_pkg::VEC_T0, 16);
    ret_cmd(1'b1);
    expect_call(irq_clk_pkg::VEC_T1, 16);
    ret_cmd(1'b1);
    repeat (12) @(negedge clk);
    bus_rd(irq_clk_pkg::ADDR_IRQ_CTL, 8'h0f);
    chk(32'(pops - p0), 32'h0000_0003);
    // Plain return leaves the global enable alone
    bus_wr(irq_clk_pkg::ADDR_IRQ_CTL, 8'h25);
    expect_call(irq_clk_pkg::VEC_T0, 8);
    ret_cmd(1'b0);
    repeat (8) @(negedge clk);
    bus_rd(irq_clk_pkg::ADDR_IRQ_CTL, 8'h04);
    $display("test prio done");
  endtask

  task automatic t_full;
    int c0;
    do_reset;
    repeat (4) begin
      @(posedge clk);
      call_req <= 1'b1;
      @(posedge clk);
      call_req <= 1'b0;
    end
    c0 = calls;
    bus_wr(irq_clk_pkg::ADDR_IRQ_CTL, 8'h25);
    repeat (20) @(negedge clk);
    chk(32'(calls - c0), 32'h0000_0000);
    bus_rd(irq_clk_pkg::ADDR_IRQ_CTL, 8'h25);
    ret_cmd(1'b0);
    expect_call(irq_clk_pkg::VEC_T0, 24);
    $display("test full done");
  endtask

  task automatic t_halt;
    int w0;
    do_reset;
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      halt_cmd <= 1'b1;
      @(posedge clk);
      halt_cmd <= 1'b0;
      repeat (3) @(negedge clk);
      chk(32'(op_mode), 32'(irq_clk_pkg::OPM_IDLE));
      chk({31'h0, sys_osc_run}, 32'h0000_0000);
      chk({31'h0, rtc_osc_run}, 32'h0000_0001);
      chk({31'h0, wdt_osc_run}, 32'h0000_0001);
      w0 = wakes;
      src(3'b001 << s);
      repeat (4) @(negedge clk);
      chk(32'(wakes - w0), 32'h0000_0001);
      chk(32'(op_mode), 32'(irq_clk_pkg::OPM_NORMAL));
    end
    $display("test halt done");
  endtask

  task automatic t_clk;
    bus_wr(irq_clk_pkg::ADDR_CLKCTL, 8'h01);
    repeat (2) @(negedge clk);
    chk(32'(op_mode), 32'(irq_clk_pkg::OPM_SLOW));
    chk({30'h0, sys_clk_is_rtc, rc_osc_run}, 32'h0000_0002);
    bus_wr(irq_clk_pkg::ADDR_CLKCTL, 8'h00);
    repeat (2) @(negedge clk);
    chk({30'h0, sys_clk_is_rtc, rc_osc_run}, 32'h0000_0001);
    // Walk every oscillator option; odd ones also turn the watchdog off
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      osc_mode        <= irq_clk_pkg::osc_mode_t'(m);
      irc_freq        <= irq_clk_pkg::irc_freq_t'(m % 3);
      wdt_osc_disable <= m[0];
      repeat (3) @(negedge clk);
      chk({31'h0, osc_pins_are_io}, 32'(m == 2));
      chk(32'(irc_freq_sel), 32'(irc_freq));
      chk({31'h0, wdt_osc_run}, 32'(!m[0]));
    end
    $display("test clk done");
  endtask

  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole run needs a few hundred cycles; a hang trips this
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    test_done;
  end

  initial begin
    do_reset;
    t_regs;
    t_ext;
    t_prio;
    t_full;
    t_halt;
    t_clk;
    test_done;
  end
endmodule
